/* hw/frm_pkg.sv */
package frm_pkg;
   // Register word addresses on the plain register port.
   localparam logic [3:0] FRM_ADDR_CTRL = 4'h0;
   localparam logic [3:0] FRM_ADDR_STATUS = 4'h1;
   localparam logic [3:0] FRM_ADDR_CLEAR = 4'h2;
   localparam logic [3:0] FRM_ADDR_LIVE = 4'h3;
   // Control register fields.
   localparam int FRM_CTRL_FREQ_LSB = 0;
   localparam int FRM_CTRL_INH_BIT = 3;
   localparam int FRM_CTRL_VB_LSB = 4;
   localparam logic [15:0] FRM_CTRL_RESET = 16'h0001;
   // Status and clear bit positions.
   localparam int FRM_ST_FREQ_HIGH = 0;
   localparam int FRM_ST_FREQ_LOW = 1;
   localparam int FRM_ST_INH_U = 2;
   localparam int FRM_ST_INH_V = 3;
   localparam int FRM_ST_INH_W = 4;
   localparam int FRM_ST_VB_LOW = 5;
   localparam int FRM_ST_BITS = 6;
   // Response selections.
   localparam logic [2:0] FRM_SEL_OFF = 3'h0;
   localparam logic [2:0] FRM_SEL_RUN = 3'h1;
   localparam logic [2:0] FRM_SEL_ALL9 = 3'h2;
   localparam logic [2:0] FRM_SEL_MOTOR6 = 3'h3;
   localparam logic [2:0] FRM_SEL_ALL9_CP = 3'h4;
   localparam logic [2:0] FRM_SEL_ALL9_CP_HOLD = 3'h5;
   // Filter and self-test timing.
   localparam int FRM_CLK_HZ = 20000000;
   localparam int FRM_FILTER_NS = 2000;
   localparam int FRM_FILTER_CYC = (FRM_FILTER_NS * (FRM_CLK_HZ / 1000000) + 999) / 1000;
   localparam int FRM_BIST_NS = 5000;
   localparam int FRM_BIST_CYC = (FRM_BIST_NS * (FRM_CLK_HZ / 1000000) + 999) / 1000;

   typedef struct packed {
      logic [2:0] high;
      logic [2:0] low;
      logic [2:0] relay;
   } frm_gate_t;

   typedef struct packed {
      logic pump_supply_switch;
      logic pump_driver_run;
      logic osc_enable;
      logic power_ok;
   } frm_supply_t;

   typedef enum logic [1:0] {
      FRM_PWR_DOWN,
      FRM_PWR_BIST,
      FRM_PWR_FAIL,
      FRM_PWR_RUN
   } frm_pwr_t;
endpackage

/* hw/frm_fault_response_manager.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Frequency selection 001 runs, 010 nine off, 011 six off, 100/101 nine plus pump.
// - Inhibit input turns its phase off; selection 1 also sets phase status and pin.
// - Retained status holds until software writes one to its clear bit.
// - Clear write is ignored while the detector still reports the error.
// - Without a clear bit, status is never set, not even while detection lasts.
// - Settings marked as not affecting the pin keep the fault indicator high.
// - Fault indicator low while any retained status is set, high when all cleared.
// - Non-retaining modes never pull the fault indicator low, not even during detection.
// - Latched responses last until status clears; others end with detection.
// - Selections are writable anytime but apply only while status shows no error.
// - Pump off opens the supply switch and halts the pump driver.
// - Nine off drives every gate low; six off spares the relay channels.
// - Faulty phase off drives high and low gate of that phase only low.
// - Without the safety clock the frequency response runs but the pin stays high.
// - Logic-supply undervoltage is either of two comparator flags high.
// - Logic undervoltage drops power ok, pin, all gates, pump and oscillator.
// - After logic undervoltage, self-test; pass restarts, fail keeps off and pin low.
// - Battery undervoltage after filtering turns nine gates off; oscillator runs, pump runs unless its selection is 100/101.
// - Selection change during battery undervoltage waits for end and clear.
module frm_fault_response_manager #(
   parameter int FILTER_CYC = frm_pkg::FRM_FILTER_CYC,
   parameter int BIST_CYC = frm_pkg::FRM_BIST_CYC
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Raw comparator outputs
   input wire logic freq_high_cmp_i,
   input wire logic freq_low_cmp_i,
   input wire logic vb_low_cmp_i,
   input wire logic logic_supply_low_flag_a_i,
   input wire logic logic_supply_low_flag_b_i,
   input wire logic [2:0] inhibit_i,
   input wire logic safety_osc_clock_ok_i,
   // Self-test result
   input wire logic bist_pass_i,
   // Commanded gate drive
   input wire frm_pkg::frm_gate_t gate_cmd_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   // Outputs
   output frm_pkg::frm_gate_t gate_o,
   output frm_pkg::frm_supply_t supply_o,
   output logic fault_indicator_n_o
);
   import frm_pkg::*;

   localparam int NDET = 3;
   localparam int CW = $clog2(FILTER_CYC + 1);
   localparam int BW = $clog2(BIST_CYC + 1);

   // A zero count would leave the filter or the self-test window without an end point.
   if (FILTER_CYC < 1 || BIST_CYC < 1) begin : g_bad_count
      $error("Filter and self-test counts must be at least one.");
   end

   logic rst_s1_reg, rst_s2_reg;
   wire logic rst_n = rst_s2_reg;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   // Filters: index 0 frequency high, 1 frequency low, 2 battery low.
   logic [NDET-1:0] cmp_raw;
   logic [NDET-1:0] det_reg;
   assign cmp_raw = {vb_low_cmp_i, freq_low_cmp_i, freq_high_cmp_i};

   // A single low sample restarts the count, so a chattering comparator never trips.
   genvar gi;
   generate
      for (gi = 0; gi < NDET; gi++) begin : g_filt
         logic [CW-1:0] cnt_reg;
         always_ff @(posedge mclk_i or negedge rst_n) begin
            if (!rst_n) begin
               cnt_reg <= '0;
               det_reg[gi] <= 1'b0;
            end else if (!cmp_raw[gi]) begin
               cnt_reg <= '0;
               det_reg[gi] <= 1'b0;
            end else if (cnt_reg >= CW'(FILTER_CYC - 1)) begin
               det_reg[gi] <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + CW'(1);
            end
         end
      end
   endgenerate

   wire logic freq_det = det_reg[0] | det_reg[1];
   wire logic vb_det = det_reg[2];
   wire logic logic_low = logic_supply_low_flag_a_i | logic_supply_low_flag_b_i;

   // Written selections and the copies that actually steer the response.
   logic [2:0] freq_sel_reg, freq_act_reg;
   logic inh_sel_reg, inh_act_reg;
   logic [2:0] vb_sel_reg, vb_act_reg;
   logic [FRM_ST_BITS-1:0] status_reg;

   // Write decode; the status and live words are read-only, so writes there are dropped.
   function automatic logic wr_hit(input logic wr, input logic [3:0] addr,
                                   input logic [3:0] want);
      wr_hit = wr && addr == want;
   endfunction

   wire logic ctrl_wr = wr_hit(reg_wr_i, reg_addr_i, FRM_ADDR_CTRL);
   wire logic clr_wr = wr_hit(reg_wr_i, reg_addr_i, FRM_ADDR_CLEAR);

   // Selections are stored at once; the active copies below decide when they apply.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         freq_sel_reg <= FRM_CTRL_RESET[FRM_CTRL_FREQ_LSB +: 3];
         inh_sel_reg <= FRM_CTRL_RESET[FRM_CTRL_INH_BIT];
         vb_sel_reg <= FRM_CTRL_RESET[FRM_CTRL_VB_LSB +: 3];
      end else if (ctrl_wr) begin
         freq_sel_reg <= reg_wdata_i[FRM_CTRL_FREQ_LSB +: 3];
         inh_sel_reg <= reg_wdata_i[FRM_CTRL_INH_BIT];
         vb_sel_reg <= reg_wdata_i[FRM_CTRL_VB_LSB +: 3];
      end
   end

   // A selection is adopted only while its monitor shows neither status nor detection.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         freq_act_reg <= FRM_CTRL_RESET[FRM_CTRL_FREQ_LSB +: 3];
         inh_act_reg <= FRM_CTRL_RESET[FRM_CTRL_INH_BIT];
         vb_act_reg <= FRM_CTRL_RESET[FRM_CTRL_VB_LSB +: 3];
      end else begin
         if (!freq_det && status_reg[FRM_ST_FREQ_LOW:FRM_ST_FREQ_HIGH] == 2'h0) begin
            freq_act_reg <= freq_sel_reg;
         end
         if (inhibit_i == 3'h0 && status_reg[FRM_ST_INH_W:FRM_ST_INH_U] == 3'h0) begin
            inh_act_reg <= inh_sel_reg;
         end
         if (!vb_det && !status_reg[FRM_ST_VB_LOW]) begin
            vb_act_reg <= vb_sel_reg;
         end
      end
   end

   function automatic logic retains(input logic [2:0] sel);
      retains = sel != FRM_SEL_OFF;
   endfunction

   // Selection 000 disables a monitor: no status and no pin. Battery undervoltage still
   // forces the gates off, because that response does not depend on the selection.
   logic freq_on, vb_on;
   assign freq_on = retains(freq_act_reg);
   assign vb_on = retains(vb_act_reg);

   // Status: detection sets, clear-by-one only when the detector is quiet.
   logic [FRM_ST_BITS-1:0] det_vec, ret_vec;
   always_comb begin
      det_vec = '0;
      ret_vec = '0;
      det_vec[FRM_ST_FREQ_HIGH] = det_reg[0] & freq_on;
      det_vec[FRM_ST_FREQ_LOW] = det_reg[1] & freq_on;
      det_vec[FRM_ST_INH_W:FRM_ST_INH_U] = inh_act_reg ? inhibit_i : 3'h0;
      det_vec[FRM_ST_VB_LOW] = vb_det & vb_on;
      ret_vec[FRM_ST_FREQ_LOW:FRM_ST_FREQ_HIGH] = {2{freq_on}};
      ret_vec[FRM_ST_INH_W:FRM_ST_INH_U] = {3{inh_act_reg}};
      ret_vec[FRM_ST_VB_LOW] = vb_on;
   end

   generate
      // Detection is tested first, so a clear in the cycle of a new event loses.
      for (gi = 0; gi < FRM_ST_BITS; gi++) begin : g_stat
         always_ff @(posedge mclk_i or negedge rst_n) begin
            if (!rst_n) begin
               status_reg[gi] <= 1'b0;
            end else if (det_vec[gi]) begin
               status_reg[gi] <= 1'b1;
            end else if (!ret_vec[gi]) begin
               status_reg[gi] <= 1'b0;
            end else if (clr_wr && reg_wdata_i[gi]) begin
               status_reg[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Power sequencing for logic-supply undervoltage and self-test.
   frm_pwr_t pwr_reg;
   logic [BW-1:0] bist_cnt_reg;
   logic bist_done;
   assign bist_done = bist_cnt_reg >= BW'(BIST_CYC - 1);

   // The self-test window starts again from zero after every logic-supply dip.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         bist_cnt_reg <= '0;
      end else if (logic_low || pwr_reg != FRM_PWR_BIST) begin
         bist_cnt_reg <= '0;
      end else if (!bist_done) begin
         bist_cnt_reg <= bist_cnt_reg + BW'(1);
      end
   end

   // A failed self-test is final until the logic supply dips again.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pwr_reg <= FRM_PWR_BIST;
      end else if (logic_low) begin
         pwr_reg <= FRM_PWR_DOWN;
      end else begin
         unique case (pwr_reg)
            FRM_PWR_DOWN: begin
               pwr_reg <= FRM_PWR_BIST;
            end
            FRM_PWR_BIST: begin
               if (bist_done) begin
                  pwr_reg <= bist_pass_i ? FRM_PWR_RUN : FRM_PWR_FAIL;
               end
            end
            FRM_PWR_FAIL: begin
               pwr_reg <= FRM_PWR_FAIL;
            end
            FRM_PWR_RUN: begin
               pwr_reg <= FRM_PWR_RUN;
            end
         endcase
      end
   end

   // Response decode: latched selection keeps its response while status is held.
   function automatic logic [2:0] resp(input logic [2:0] sel, input logic act,
                                       input logic held);
      // Bit 2 nine off, bit 1 six off, bit 0 pump off.
      resp = 3'h0;
      if (act || (held && sel == FRM_SEL_ALL9_CP_HOLD)) begin
         unique case (sel)
            FRM_SEL_ALL9: resp = 3'h4;
            FRM_SEL_MOTOR6: resp = 3'h2;
            FRM_SEL_ALL9_CP, FRM_SEL_ALL9_CP_HOLD: resp = 3'h5;
            default: resp = 3'h0;
         endcase
      end
   endfunction

   // Inhibit cuts its phase whatever the selection; the selection only decides status.
   logic [2:0] freq_resp, vb_resp;
   logic [2:0] phase_off;
   logic all_off, motor_off, pump_off, run_ok;
   always_comb begin
      freq_resp = resp(freq_act_reg, freq_det,
                       |status_reg[FRM_ST_FREQ_LOW:FRM_ST_FREQ_HIGH]);
      vb_resp = resp(vb_act_reg, vb_det, status_reg[FRM_ST_VB_LOW]);
      run_ok = pwr_reg == FRM_PWR_RUN && !logic_low;
      phase_off = inhibit_i;
      all_off = freq_resp[2] | vb_resp[2] | vb_det | !run_ok;
      motor_off = freq_resp[1] | vb_resp[1];
      pump_off = freq_resp[0] | vb_resp[0] | !run_ok;
   end

   // One gate stage for each phase; the relay channel obeys only the nine-channel cut.
   generate
      for (gi = 0; gi < 3; gi++) begin : g_phase
         wire logic phase_run = !all_off && !motor_off && !phase_off[gi];
         always_ff @(posedge mclk_i or negedge rst_n) begin
            if (!rst_n) begin
               gate_o.high[gi] <= 1'b0;
               gate_o.low[gi] <= 1'b0;
               gate_o.relay[gi] <= 1'b0;
            end else begin
               gate_o.high[gi] <= gate_cmd_i.high[gi] & phase_run;
               gate_o.low[gi] <= gate_cmd_i.low[gi] & phase_run;
               gate_o.relay[gi] <= gate_cmd_i.relay[gi] & !all_off;
            end
         end
      end
   endgenerate

   // Both halves of the charge pump switch together, so the pump never runs unsupplied.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         supply_o.pump_supply_switch <= 1'b0;
         supply_o.pump_driver_run <= 1'b0;
      end else begin
         supply_o.pump_supply_switch <= !pump_off;
         supply_o.pump_driver_run <= !pump_off;
      end
   end

   // Battery undervoltage leaves the oscillator alone; only the logic supply stops it.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         supply_o.osc_enable <= 1'b0;
         supply_o.power_ok <= 1'b0;
      end else begin
         supply_o.osc_enable <= !logic_low;
         supply_o.power_ok <= !logic_low;
      end
   end

   // The frequency monitor cannot pull the pin when the safety clock is gone.
   logic pin_low;
   always_comb begin
      pin_low = |status_reg[FRM_ST_VB_LOW:FRM_ST_INH_U];
      if (safety_osc_clock_ok_i) begin
         pin_low = pin_low | (|status_reg[FRM_ST_FREQ_LOW:FRM_ST_FREQ_HIGH]);
      end
      pin_low = pin_low | !run_ok;
   end

   // The indicator starts low and rises only once the self-test has passed.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         fault_indicator_n_o <= 1'b0;
      end else begin
         fault_indicator_n_o <= !pin_low;
      end
   end

   // Read data stand for one cycle only; an idle port reads as zero, never a stale word.
   logic [15:0] rd_word;
   always_comb begin
      unique case (reg_addr_i)
         FRM_ADDR_CTRL: rd_word = {9'h000, vb_sel_reg, inh_sel_reg, freq_sel_reg};
         FRM_ADDR_STATUS: rd_word = {10'h000, status_reg};
         FRM_ADDR_LIVE: rd_word = {11'h000, pwr_reg, det_reg};
         default: rd_word = 16'h0000;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= '0;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_word : 16'h0000;
      end
   end
endmodule
`default_nettype wire

/* verification/frm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module frm_monitor
   import frm_pkg::*;
(
   // Clock, reset and inputs
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic logic_supply_low_flag_a_i,
   input wire logic logic_supply_low_flag_b_i,
   input wire logic vb_low_cmp_i,
   input wire logic [2:0] inhibit_i,
   input wire logic reg_rd_i,
   input wire frm_gate_t gate_cmd_i,
   // Outputs
   input wire logic [15:0] reg_rdata_o,
   input wire frm_gate_t gate_o,
   input wire frm_supply_t supply_o,
   input wire logic fault_indicator_n_o
);
   logic low_v;
   assign low_v = logic_supply_low_flag_a_i | logic_supply_low_flag_b_i;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   sequence logic_low_s;
      low_v [*3];
   endsequence
   rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data outside read cycle");
   logic_low_off_a: assert property (logic_low_s |-> !supply_o.power_ok && !supply_o.osc_enable
      && !fault_indicator_n_o) else $error("logic undervoltage not handled");
   pump_pair_a: assert property (supply_o.pump_supply_switch == supply_o.pump_driver_run)
      else $error("pump switch and driver differ");
   inhibit_off_a: assert property (((inhibit_i & $past(inhibit_i) & $past(inhibit_i, 2))
      & (gate_o.high | gate_o.low)) == 3'h0) else $error("inhibited phase driven");
   gate_mask_a: assert property ((gate_o & ~$past(gate_cmd_i)) == 9'h000)
      else $error("gate on without command");
   power_gates_a: assert property (!supply_o.power_ok |-> gate_o == 9'h000)
      else $error("gates on without power ok");
   vb_off_a: assert property (vb_low_cmp_i [*6] |-> gate_o == 9'h000)
      else $error("gates on in battery undervoltage");
   osc_cause_a: assert property ($fell(supply_o.osc_enable) |-> $past(low_v)
      || $past(low_v, 2) || $past(low_v, 3)) else $error("oscillator stopped without cause");
endmodule
bind frm_fault_response_manager frm_monitor i_mon (.mclk_i, .rst_n_i,
   .logic_supply_low_flag_a_i, .logic_supply_low_flag_b_i, .vb_low_cmp_i, .inhibit_i,
   .reg_rd_i, .gate_cmd_i, .reg_rdata_o, .gate_o, .supply_o, .fault_indicator_n_o);
`default_nettype wire

/* verification/frm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module frm_host_model
   import frm_pkg::*;
(
   // Clock
   input wire logic mclk_i,
   // Register port toward the device
   output logic [3:0] reg_addr_o,
   output logic [15:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   input wire logic [15:0] reg_rdata_i
);
   initial begin
      reg_addr_o = 4'h0;
      reg_wdata_o = 16'h0000;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge mclk_i);
      reg_wr_o <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge mclk_i);
      reg_rd_o <= 1'b0;
      @(posedge mclk_i);
      d = reg_rdata_i;
   endtask
   // The host clears with one write to the clear word; it does not wait for the fault to go away.
   task automatic clr(input logic [15:0] m);
      wr(FRM_ADDR_CLEAR, m);
   endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import frm_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic fh, fl, vb, la, lb, ok, bp;
   logic [2:0] inh;
   frm_gate_t cmd;
   frm_gate_t gate;
   frm_supply_t sup;
   logic pin, wr, rd;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, rv;
   int n_fail = 0, total_checks = 0, cycles = 0;
   always #25 mclk_i = ~mclk_i;
   frm_fault_response_manager #(.FILTER_CYC(2), .BIST_CYC(3)) i_dut (.mclk_i(mclk_i),
      .rst_n_i(rst_n_i), .freq_high_cmp_i(fh), .freq_low_cmp_i(fl), .vb_low_cmp_i(vb),
      .logic_supply_low_flag_a_i(la), .logic_supply_low_flag_b_i(lb), .inhibit_i(inh),
      .safety_osc_clock_ok_i(ok), .bist_pass_i(bp), .gate_cmd_i(cmd), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .gate_o(gate),
      .supply_o(sup), .fault_indicator_n_o(pin));
   frm_host_model i_host (.mclk_i(mclk_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
      .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rdchk(input string what, input logic [3:0] a, input logic [15:0] m,
                        input logic [15:0] exp);
      i_host.rd(a, rv);
      chk(what, rv & m, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // The whole sequence needs well under a thousand cycles.
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   initial begin
      {fh, fl, vb, la, lb} <= 5'h00;
      {ok, bp} <= 2'h3;
      inh <= 3'h0;
      cmd <= 9'h1FF;
      cyc(2);
      rst_n_i <= 1'b1;
      cyc(12);
      rdchk("ctrl", FRM_ADDR_CTRL, 16'hFFFF, FRM_CTRL_RESET);
      rdchk("power state", FRM_ADDR_LIVE, 16'h0018, 16'h0018);
      rdchk("unmapped", 4'hF, 16'hFFFF, 16'h0000);
      $display("test reset done");
      for (int s = 1; s <= 5; s++) begin
         i_host.wr(FRM_ADDR_CTRL, 16'(s));
         fh <= 1'b1;
         cyc(6);
         i_host.clr(16'h0001);
         chk("gates", {7'h0, gate}, s == 1 ? 16'h01FF : s == 3 ? 16'h0007 : 16'h0000);
         chk("pump", {15'h0, sup.pump_supply_switch}, 16'(s < 4));
         rdchk("status", FRM_ADDR_STATUS, 16'h0003, 16'h0001);
         fh <= 1'b0;
         cyc(4);
         chk("held gates", {7'h0, gate}, s == 5 ? 16'h0000 : 16'h01FF);
         chk("pin", {15'h0, pin}, 16'h0000);
         i_host.clr(16'h0001);
         cyc(4);
         chk("pin", {15'h0, pin}, 16'h0001);
         chk("gates", {7'h0, gate}, 16'h01FF);
      end
      $display("test frequency codes done");
      ok <= 1'b0;
      i_host.wr(FRM_ADDR_CTRL, 16'h0002);
      fl <= 1'b1;
      cyc(6);
      chk("gates", {7'h0, gate}, 16'h0000);
      chk("pin", {15'h0, pin}, 16'h0001);
      rdchk("status", FRM_ADDR_STATUS, 16'h0003, 16'h0002);
      fl <= 1'b0;
      ok <= 1'b1;
      cyc(4);
      i_host.clr(16'h0002);
      i_host.wr(FRM_ADDR_CTRL, 16'h0000);
      fh <= 1'b1;
      cyc(6);
      chk("pin", {15'h0, pin}, 16'h0001);
      chk("gates", {7'h0, gate}, 16'h01FF);
      rdchk("status", FRM_ADDR_STATUS, 16'h003F, 16'h0000);
      fh <= 1'b0;
      $display("test clock loss and disabled done");
      for (int b = 0; b < 2; b++) begin
         i_host.wr(FRM_ADDR_CTRL, 16'(b << 3));
         // The selection is adopted only while no phase is inhibited.
         cyc(1);
         inh <= 3'h2;
         cyc(5);
         chk("gates", {7'h0, gate}, 16'h016F);
         chk("pin", {15'h0, pin}, 16'(b == 0));
         rdchk("status", FRM_ADDR_STATUS, 16'h001C, 16'(b << 3));
         inh <= 3'h0;
         cyc(4);
         chk("pin", {15'h0, pin}, 16'(b == 0));
         i_host.clr(16'h001C);
         cyc(3);
      end
      $display("test inhibit done");
      i_host.wr(FRM_ADDR_CTRL, 16'h0011);
      vb <= 1'b1;
      cyc(8);
      chk("gates", {7'h0, gate}, 16'h0000);
      chk("osc pump", {14'h0, sup.osc_enable, sup.pump_supply_switch}, 16'h0003);
      i_host.wr(FRM_ADDR_CTRL, 16'h0001);
      vb <= 1'b0;
      cyc(5);
      chk("gates", {7'h0, gate}, 16'h01FF);
      chk("pin", {15'h0, pin}, 16'h0000);
      i_host.clr(16'h0020);
      cyc(3);
      chk("pin", {15'h0, pin}, 16'h0001);
      vb <= 1'b1;
      cyc(8);
      rdchk("status", FRM_ADDR_STATUS, 16'h0020, 16'h0000);
      vb <= 1'b0;
      i_host.wr(FRM_ADDR_STATUS, 16'hFFFF);
      rdchk("status", FRM_ADDR_STATUS, 16'h003F, 16'h0000);
      cmd <= 9'h0A5;
      cyc(2);
      chk("gate routing", {7'h0, gate}, 16'h00A5);
      cmd <= 9'h1FF;
      $display("test battery done");
      lb <= 1'b1;
      cyc(4);
      rdchk("power state", FRM_ADDR_LIVE, 16'h0018, 16'h0000);
      lb <= 1'b0;
      cyc(12);
      rdchk("power state", FRM_ADDR_LIVE, 16'h0018, 16'h0018);
      chk("pin", {15'h0, pin}, 16'h0001);
      bp <= 1'b0;
      la <= 1'b1;
      cyc(4);
      la <= 1'b0;
      cyc(12);
      rdchk("power state", FRM_ADDR_LIVE, 16'h0018, 16'h0010);
      chk("pin", {15'h0, pin}, 16'h0000);
      chk("gates", {7'h0, gate}, 16'h0000);
      $display("test logic supply done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
